// ==== hw/flash_map_pkg.sv ====
// Package with option-word layout, register offsets and codes for flash map
package flash_map_pkg;

  // ==========================================================
  // Register offsets (software port, word addresses as printed)
  localparam logic [31:0] OFS_BANK_MODE      = 32'h0100a110;
  localparam logic [31:0] OFS_BANK_NS        = 32'h0100a114;
  localparam logic [31:0] OFS_BANK_SEC       = 32'h0100a118;
  localparam logic [31:0] OFS_BANK_SEL       = 32'h0100a11c;
  localparam logic [31:0] OFS_TMP_NS         = 32'h0100a120;
  localparam logic [31:0] OFS_TMP_SEC        = 32'h0100a124;
  localparam logic [31:0] OFS_TMP_SEL        = 32'h0100a128;
  localparam logic [31:0] OFS_PRM_NS         = 32'h0100a12c;
  localparam logic [31:0] OFS_PRM_SEC        = 32'h0100a130;
  localparam logic [31:0] OFS_PRM_SEL        = 32'h0100a134;
  localparam logic [31:0] OFS_STATUS         = 32'h0100a138;

  // ==========================================================
  // Option word codes and reset values
  localparam logic [31:0] SEL_NONSECURE      = 32'hfffffff8;
  localparam logic [31:0] SEL_SECURE         = 32'hffffffff;
  localparam logic [31:0] OPT_BLANK          = 32'hffffffff;
  localparam logic [2:0]  MODE_DUAL          = 3'h0;
  localparam int          MODE_LSB           = 0;
  localparam int          SWAP_LSB           = 0;
  localparam logic [2:0]  SWAP_BANK0         = 3'h7;

  // ==========================================================
  // Flash geometry
  localparam logic [31:0] FLASH_SIZE         = 32'h00100000;
  localparam logic [31:0] HALF_SIZE          = FLASH_SIZE >> 1;
  localparam logic [31:0] UPPER_DUAL_BASE    = 32'h00200000;
  localparam logic [31:0] BLOCK_SIZE         = 32'h00008000;
  localparam int          NUM_BLOCKS         = 32;
  localparam int          BLK_W              = 5;
  localparam int          BLK_LSB            = 15;

  // ==========================================================
  // Program or erase request from the sequencer
  typedef struct packed {
    logic        valid;
    logic        erase;
    logic [31:0] addr;
  } pe_req_t;

  typedef struct packed {
    logic           hit;
    logic           upper;
    logic [BLK_W-1:0] block;
  } map_res_t;

endpackage

// ==== hw/flash_addr_map.sv ====
// Address to block translator for linear and dual bank layouts
`timescale 1ns/1ps
module flash_addr_map (
  // Mapping mode
  input  wire logic                      dual_in,
  input  wire logic                      swap_in,
  // Address to translate
  input  wire logic [31:0]               addr_in,
  // Result
  output flash_map_pkg::map_res_t        res_out
);
  import flash_map_pkg::*;

  logic [31:0] offs;
  logic        up;

  always_comb begin
    res_out = '0;
    offs    = 32'h0;
    up      = 1'b0;
    if (!dual_in) begin
      // Linear upper half at half size
      res_out.hit = (addr_in < FLASH_SIZE);
      up          = (addr_in >= HALF_SIZE);
      offs        = addr_in;
    end else if (addr_in < HALF_SIZE) begin
      res_out.hit = 1'b1;
      up          = 1'b0;
      offs        = addr_in;
    end else if (addr_in >= UPPER_DUAL_BASE &&
                 addr_in < UPPER_DUAL_BASE + HALF_SIZE) begin
      res_out.hit = 1'b1;
      up          = 1'b1;
      offs        = addr_in - UPPER_DUAL_BASE + HALF_SIZE;
    end
    // Swapped startup bank exchanges the physical halves
    if (dual_in && swap_in) begin
      up   = ~up;
      offs = offs ^ HALF_SIZE;
    end
    res_out.upper = up;
    res_out.block = offs[BLK_LSB +: BLK_W];
  end

endmodule

// ==== hw/flash_bank_protect.sv ====
// Code flash bank mapping and block protection from option words
`timescale 1ns/1ps
module flash_bank_protect (
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      sys_rst_in,
  // Register port
  input  wire logic [31:0]               reg_addr_in,
  input  wire logic [31:0]               reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  input  wire logic                      reg_secure_in,
  output logic      [31:0]               reg_rdata_out,
  // Program or erase request
  input  wire flash_map_pkg::pe_req_t    pe_req_in,
  output logic                           pe_grant_out,
  output logic                           pe_reject_out,
  output logic      [4:0]                pe_block_out,
  // Mapping state
  output logic                           dual_mode_out,
  output logic                           startup_upper_out
);
  import flash_map_pkg::*;

  // ==========================================================
  // Option words, nonvolatile in the real part
  logic [31:0] bank_mode, bank_ns, bank_sec, bank_sel;
  logic [31:0] tmp_ns, tmp_sec, tmp_sel, prm_ns, prm_sec, prm_sel;
  logic [31:0] next_bank_mode, next_bank_ns, next_bank_sec, next_bank_sel;
  logic [31:0] next_tmp_ns, next_tmp_sec, next_tmp_sel;
  logic [31:0] next_prm_ns, next_prm_sec, next_prm_sel;
  logic        wr_ok;

  always_comb begin
    next_bank_mode = bank_mode;
    next_bank_ns   = bank_ns;
    next_bank_sec  = bank_sec;
    next_bank_sel  = bank_sel;
    next_tmp_ns    = tmp_ns;
    next_tmp_sec   = tmp_sec;
    next_tmp_sel   = tmp_sel;
    next_prm_ns    = prm_ns;
    next_prm_sec   = prm_sec;
    next_prm_sel   = prm_sel;
    wr_ok          = reg_wr_in;
    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_BANK_MODE: next_bank_mode = reg_wdata_in;
        OFS_BANK_NS:   next_bank_ns   = reg_wdata_in;
        OFS_TMP_NS:    next_tmp_ns    = reg_wdata_in;
        OFS_PRM_NS:    next_prm_ns    = reg_wdata_in;
        default: begin
          if (reg_secure_in) begin
            case (reg_addr_in)
              OFS_BANK_SEC: next_bank_sec = reg_wdata_in;
              OFS_BANK_SEL: next_bank_sel = reg_wdata_in;
              OFS_TMP_SEC:  next_tmp_sec  = reg_wdata_in;
              OFS_TMP_SEL:  next_tmp_sel  = reg_wdata_in;
              OFS_PRM_SEC:  next_prm_sec  = reg_wdata_in;
              OFS_PRM_SEL:  next_prm_sel  = reg_wdata_in;
              default:      wr_ok         = 1'b0;
            endcase
          end else begin
            wr_ok = 1'b0;
          end
        end
      endcase
    end
  end

  // Option words survive reset; only a blank part starts all ones
  // Power-up flag: without a known start the blank load never happens
  logic init_done = 1'b0;

  always_ff @(posedge ref_clk_in) begin
    if (!init_done) begin
      bank_mode <= OPT_BLANK;
      bank_ns   <= OPT_BLANK;
      bank_sec  <= OPT_BLANK;
      bank_sel  <= OPT_BLANK;
      tmp_ns    <= OPT_BLANK;
      tmp_sec   <= OPT_BLANK;
      tmp_sel   <= OPT_BLANK;
      prm_ns    <= OPT_BLANK;
      prm_sec   <= OPT_BLANK;
      prm_sel   <= OPT_BLANK;
    end else begin
      bank_mode <= next_bank_mode;
      bank_ns   <= next_bank_ns;
      bank_sec  <= next_bank_sec;
      bank_sel  <= next_bank_sel;
      tmp_ns    <= next_tmp_ns;
      tmp_sec   <= next_tmp_sec;
      tmp_sel   <= next_tmp_sel;
      prm_ns    <= next_prm_ns;
      prm_sec   <= next_prm_sec;
      prm_sel   <= next_prm_sel;
    end
  end

  // ==========================================================
  // Latched configuration, loaded only under reset
  logic        dual, swap, next_dual, next_swap;
  logic [31:0] tmp_eff, prm_eff, next_tmp_eff, next_prm_eff;
  logic [31:0] bank_eff;

  always_comb begin
    bank_eff = (bank_sel == SEL_NONSECURE) ? bank_ns : bank_sec;
    next_dual = (bank_mode[MODE_LSB +: 3] == MODE_DUAL);
    // Blank swap field is bank 0
    next_swap = next_dual && (bank_eff[SWAP_LSB +: 3] != SWAP_BANK0);
    next_tmp_eff = (tmp_sel == SEL_NONSECURE) ? tmp_ns : tmp_sec;
    next_prm_eff = (prm_sel == SEL_NONSECURE) ? prm_ns : prm_sec;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      init_done <= 1'b1;
      dual      <= init_done ? next_dual : 1'b0;
      swap      <= init_done ? next_swap : 1'b0;
      tmp_eff   <= init_done ? next_tmp_eff : OPT_BLANK;
      prm_eff   <= init_done ? next_prm_eff : OPT_BLANK;
    end
  end

  // ==========================================================
  // Program and erase check
  map_res_t    map;
  logic        allow, next_grant, next_reject;
  logic [4:0]  next_block;
  logic [31:0] next_rdata;

  flash_addr_map u_map (
    .dual_in (dual),
    .swap_in (swap),
    .addr_in (pe_req_in.addr),
    .res_out (map)
  );

  always_comb begin
    allow       = map.hit && tmp_eff[map.block] && prm_eff[map.block];
    // Only the addressed request is refused
    next_grant  = pe_req_in.valid && allow;
    next_reject = pe_req_in.valid && !allow;
    next_block  = pe_req_in.valid ? map.block : pe_block_out;
    case (reg_addr_in)
      OFS_BANK_MODE: next_rdata = bank_mode;
      OFS_BANK_NS:   next_rdata = bank_ns;
      OFS_BANK_SEC:  next_rdata = bank_sec;
      OFS_BANK_SEL:  next_rdata = bank_sel;
      OFS_TMP_NS:    next_rdata = tmp_ns;
      OFS_TMP_SEC:   next_rdata = tmp_sec;
      OFS_TMP_SEL:   next_rdata = tmp_sel;
      OFS_PRM_NS:    next_rdata = prm_ns;
      OFS_PRM_SEC:   next_rdata = prm_sec;
      OFS_PRM_SEL:   next_rdata = prm_sel;
      OFS_STATUS:    next_rdata = {30'h0, swap, dual};
      default:       next_rdata = 32'h0;
    endcase
    if (!reg_rd_in) begin
      next_rdata = 32'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pe_grant_out  <= 1'b0;
      pe_reject_out <= 1'b0;
      pe_block_out  <= 5'h0;
      reg_rdata_out <= 32'h0;
    end else begin
      pe_grant_out  <= next_grant;
      pe_reject_out <= next_reject;
      pe_block_out  <= next_block;
      reg_rdata_out <= next_rdata;
    end
  end

  assign dual_mode_out     = dual;
  assign startup_upper_out = swap;

endmodule

// ==== dv/flash_seq_model.sv ====
// Program and erase sequencer model on the far side of the block
`timescale 1ns/1ps
module flash_seq_model (
  // Clock
  input  wire logic              ref_clk_in,
  // Request to the block
  output flash_map_pkg::pe_req_t pe_req_out
);
  import flash_map_pkg::*;
  initial pe_req_out = '0;
  // ==========================================================
  // Request cycle, released lines show the inverse value
  task automatic request(input logic er, input logic [31:0] a);
    @(posedge ref_clk_in);
    pe_req_out <= '{1'b1, er, a & ~(BLOCK_SIZE - 32'h1)};
    @(posedge ref_clk_in);
    pe_req_out <= '{1'b0, ~er, ~a};
  endtask
endmodule

// ==== dv/flash_bank_protect_properties.sv ====
// Port checker for flash mapping and block protection
`timescale 1ns/1ps
module flash_bank_protect_properties (
  // Clock and reset
  input wire logic                   ref_clk_in,
  input wire logic                   sys_rst_in,
  // Register port
  input wire logic [31:0]            reg_addr_in,
  input wire logic [31:0]            reg_wdata_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic                   reg_secure_in,
  input wire logic [31:0]            reg_rdata_out,
  // Program or erase
  input wire flash_map_pkg::pe_req_t pe_req_in,
  input wire logic                   pe_grant_out,
  input wire logic                   pe_reject_out,
  input wire logic [4:0]             pe_block_out,
  // Mapping state
  input wire logic                   dual_mode_out,
  input wire logic                   startup_upper_out
);
  import flash_map_pkg::*;
  logic [31:0] a;
  logic        v, dl, sw, up, lo;
  logic [4:0]  phys;
  assign a = pe_req_in.addr;
  assign v = pe_req_in.valid;
  assign dl = dual_mode_out;
  assign sw = startup_upper_out;
  assign up = dl && a >= UPPER_DUAL_BASE && a < UPPER_DUAL_BASE + HALF_SIZE;
  assign lo = a < (dl ? HALF_SIZE : FLASH_SIZE);
  assign phys = up ? {~sw, a[18:15]} : (dl ? {sw, a[18:15]} : a[19:15]);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // Assertions
  pe_answer_a:
    assert property (v |=> pe_grant_out != pe_reject_out)
    else $error("request without single answer");
  pe_cause_a:
    assert property ((pe_grant_out || pe_reject_out) |-> $past(v))
    else $error("answer without request");
  map_hold_a:
    assert property (!$past(sys_rst_in) |->
    $stable(dual_mode_out) && $stable(startup_upper_out))
    else $error("mapping changed outside reset");
  linear_swap_a:
    assert property (!dl |-> !sw)
    else $error("swap shown in linear mode");
  map_block_a:
    assert property (v && (up || lo) |=> pe_block_out == $past(phys))
    else $error("wrong physical block");
  linear_half_a:
    assert property (v && !dl && a == HALF_SIZE |=>
    pe_block_out == 5'h10)
    else $error("linear upper half misplaced");
  swap_lower_a:
    assert property (v && sw && a < HALF_SIZE |=> pe_block_out[4])
    else $error("swap not applied to startup bank");
  unmapped_a:
    assert property (v && !(up || lo) |=> pe_reject_out)
    else $error("unmapped address not refused");
  status_read_a:
    assert property (reg_rd_in && reg_addr_in == OFS_STATUS |=>
    reg_rdata_out == {30'h0, $past(sw), $past(dl)})
    else $error("status read wrong");
endmodule

// ==== dv/flash_bank_protect_test.sv ====
// Self-checking bench for code flash mapping and protection
`timescale 1ns/1ps
module flash_bank_protect_test;
  import flash_map_pkg::*;
  logic        clk, rst, wr, rd, sec, rd_d, pv_d, dual, upper, grant, rej;
  logic        dual_e, swap_e;
  logic [31:0] addr, wdata, rdata, seed, tm, pm;
  logic [4:0]  blk, b, c;
  logic [6:0]  n;
  pe_req_t     req;
  logic [31:0] rq[$];
  logic [6:0]  pq[$];
  int          errors, comparisons;
  flash_seq_model seq_u (.ref_clk_in(clk), .pe_req_out(req));
  flash_bank_protect dut_u (.ref_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_secure_in(sec), .reg_rdata_out(rdata), .pe_req_in(req),
    .pe_grant_out(grant), .pe_reject_out(rej), .pe_block_out(blk),
    .dual_mode_out(dual), .startup_upper_out(upper));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic s, input logic [31:0] a, d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    sec <= s;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic r(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b0, a, 32'h0);
  endtask
  // Logical address worked out from the physical block
  task automatic pe(input logic [4:0] p);
    logic [31:0] base;
    base = (p[4] ^ swap_e) ? (dual_e ? UPPER_DUAL_BASE : HALF_SIZE) : 32'h0;
    seed = xs(seed);
    pq.push_back({1'b1, !(tm[p] && pm[p]), p});
    seq_u.request(seed[0], base + {p[3:0], 15'h0} + (seed & 32'h7ffc));
  endtask
  task automatic reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic end_of_test();
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Result watcher
  always @(posedge clk) begin
    rd_d <= rd;
    pv_d <= req.valid;
  end
  always @(negedge clk) begin
    if (rd_d === 1'b1)
      chk(rdata, rq.pop_front());
    if (pv_d === 1'b1 || grant === 1'b1 || rej === 1'b1) begin
      n = pq.pop_front();
      chk(32'({grant, rej}), 32'({~n[5], n[5]}));
      if (n[6] === 1'b1)
        chk(32'(blk), 32'(n[4:0]));
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst, wr, rd, sec, addr, wdata, rd_d, pv_d} = {1'b1, 67'h0, 2'b00};
    {dual_e, swap_e, errors, comparisons} = '0;
    {tm, pm} = '1;
    seed = xs(32'd12892);
    b = seed[4:0];
    c = seed[9:5];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    r(OFS_STATUS, 32'h0);
    r(32'h0100a13c, 32'h0);
    pe(5'h10);
    pe(5'h00);
    bus(1'b1, 1'b0, OFS_BANK_SEC, 32'h0);
    r(OFS_BANK_SEC, OPT_BLANK);
    bus(1'b1, 1'b0, OFS_BANK_MODE, {29'h0, MODE_DUAL});
    bus(1'b1, 1'b1, OFS_TMP_SEC, ~(32'h1 << b));
    bus(1'b1, 1'b1, OFS_PRM_SEL, SEL_NONSECURE);
    bus(1'b1, 1'b0, OFS_PRM_NS, ~(32'h1 << c));
    r(OFS_STATUS, 32'h0);
    pe(b);
    reset();
    {dual_e, tm, pm} = {1'b1, ~(32'h1 << b), ~(32'h1 << c)};
    r(OFS_STATUS, 32'h1);
    // Every block, masks from both selector settings
    for (int i = 0; i < NUM_BLOCKS; i++)
      pe(5'(i));
    pq.push_back(7'h20);
    seq_u.request(1'b0, HALF_SIZE);
    bus(1'b1, 1'b1, OFS_BANK_SEL, SEL_NONSECURE);
    bus(1'b1, 1'b0, OFS_BANK_NS, 32'hfffffff8);
    r(OFS_STATUS, 32'h1);
    reset();
    swap_e = 1'b1;
    r(OFS_STATUS, 32'h3);
    pe(5'h10);
    pe(5'h00);
    for (int k = 0; k < 20 && rq.size() + pq.size() > 0; k++)
      @(posedge clk);
    if (rq.size() + pq.size() > 0)
      errors++;
    end_of_test();
  end
endmodule
bind flash_bank_protect flash_bank_protect_properties chk_u (.*);
